// ---- scct_edge_div.sv ----
// Capture edge divider: passes every 1st, 2nd, 4th or 8th active edge.
// Assumes i_edge is a one-cycle pulse on i_clock.
`timescale 1ns/1ns

module scct_edge_div (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_edge,
  input wire logic [1:0] i_div,
  output logic o_capture
);

  logic [2:0] edge_cnt_r;

  wire [2:0] div_mask = (i_div == 2'b00) ? 3'h0 :
                        (i_div == 2'b01) ? 3'h1 :
                        (i_div == 2'b10) ? 3'h3 : 3'h7;

  assign o_capture = i_enable && i_edge && ((edge_cnt_r & div_mask) == div_mask);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !i_enable) begin
      edge_cnt_r <= 3'h0;
    end else if (i_edge) begin
      edge_cnt_r <= edge_cnt_r + 3'h1;
    end
  end

endmodule : scct_edge_div

// ---- scct_filter.sv ----
// Digital input filter: samples a synchronised level at a divided rate and
// passes a new level only after N agreeing samples.
// Assumes the input is already synchronised to i_clock.
`timescale 1ns/1ns
`include "scct_map.svh"

module scct_filter (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_level,
  input wire logic [3:0] i_cfg,
  output logic o_filtered
);

  // Returns {sample mask, N}; a sample is taken when the free counter's
  // masked bits are all zero.
  function automatic logic [8:0] filt_decode(input logic [3:0] cfg);
    logic [8:0] res;
    res = 9'h001;
    case (cfg)
      4'h0: res = {5'h00, 4'h1};
      4'h1: res = {5'h00, 4'h2};
      4'h2: res = {5'h00, 4'h4};
      4'h3: res = {5'h00, 4'h8};
      4'h4: res = {5'h01, 4'h6};
      4'h5: res = {5'h01, 4'h8};
      4'h6: res = {5'h03, 4'h6};
      4'h7: res = {5'h03, 4'h8};
      4'h8: res = {5'h07, 4'h6};
      4'h9: res = {5'h07, 4'h8};
      4'ha: res = {5'h0f, 4'h5};
      4'hb: res = {5'h0f, 4'h6};
      4'hc: res = {5'h0f, 4'h8};
      4'hd: res = {5'h1f, 4'h5};
      4'he: res = {5'h1f, 4'h6};
      default: res = {5'h1f, 4'h8};
    endcase
    return res;
  endfunction : filt_decode

  logic [4:0] div_cnt_r;
  logic [2:0] agree_r;
  logic [2:0] agree_nxt;
  logic filt_r;
  logic filt_nxt;

  wire [8:0] dec = filt_decode(i_cfg);
  wire [4:0] samp_mask = dec[8:4];
  wire [3:0] need_n = dec[3:0];
  wire samp_tick = (div_cnt_r & samp_mask) == 5'h00;
  wire differs = i_level != filt_r;
  wire reached = ({1'b0, agree_r} + 4'h1) == need_n;

  assign agree_nxt = (!samp_tick) ? agree_r :
                     (differs && !reached) ? agree_r + 3'h1 : 3'h0;
  assign filt_nxt = (samp_tick && differs && reached) ? i_level : filt_r;
  assign o_filtered = filt_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_cnt_r <= 5'h00;
      agree_r <= 3'h0;
      filt_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
      agree_r <= agree_nxt;
      filt_r <= filt_nxt;
    end
  end

endmodule : scct_filter

// ---- scct_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// single channel capture/compare timer.
// Assumes inclusion by bare name from the timer package and modules.
`ifndef SCCT_MAP_SVH
`define SCCT_MAP_SVH

`define SCCT_ADDR_W 8
`define SCCT_DATA_W 16

`define SCCT_OFF_CTRL 8'h00
`define SCCT_OFF_MODE 8'h18
`define SCCT_OFF_OUTEN 8'h20
`define SCCT_OFF_COUNT 8'h24
`define SCCT_OFF_DIV 8'h28
`define SCCT_OFF_RELOAD 8'h2c
`define SCCT_OFF_REPEAT 8'h30
`define SCCT_OFF_CCVAL 8'h34
`define SCCT_OFF_WRITE_LOCK_LEVEL 8'h44

`define SCCT_RST16 16'h0000
`define SCCT_RST8 8'h00

`define SCCT_CTRL_CNT_EN 0
`define SCCT_CTRL_UPD_GEN 1
`define SCCT_CTRL_ONE_SHOT 3
`define SCCT_CTRL_TRIG_LO 4
`define SCCT_CTRL_TRIG_HI 5

`define SCCT_MODE_DIR_LO 0
`define SCCT_MODE_DIR_HI 1
`define SCCT_MODE_FAST 2
`define SCCT_MODE_SHADOW 3
`define SCCT_MODE_CDIV_LO 2
`define SCCT_MODE_CDIV_HI 3
`define SCCT_MODE_OCTL_LO 4
`define SCCT_MODE_OCTL_HI 6
`define SCCT_MODE_FILT_LO 4
`define SCCT_MODE_FILT_HI 7

`define SCCT_OUTEN_CHAN_EN 0
`define SCCT_OUTEN_MAIN_POL 1
`define SCCT_OUTEN_COMP_EN 2
`define SCCT_OUTEN_COMP_POL 3

`define SCCT_WRITE_LOCK_LEVEL_LEVEL_LO 8
`define SCCT_WRITE_LOCK_LEVEL_LEVEL_HI 9
`define SCCT_WRITE_LOCK_LEVEL_BRK_POL 13
`define SCCT_WRITE_LOCK_LEVEL_AUTO_EN 14
`define SCCT_WRITE_LOCK_LEVEL_PRIM_EN 15

`define SCCT_LOCK_NONE 2'b00
`define SCCT_LOCK_MID 2'b10
`define SCCT_LOCK_FULL 2'b11

`define SCCT_TRIG_NONE 2'b00
`define SCCT_TRIG_INTERNAL 2'b01
`define SCCT_TRIG_SELF 2'b10
`define SCCT_TRIG_NEIGHBOUR 2'b11

`define SCCT_FAST_LATENCY 3
`define SCCT_SLOW_LATENCY 5
`define SCCT_TRIG_PIPE_W (`SCCT_SLOW_LATENCY - 2)

`endif

// ---- scct_pkg.sv ----
// Types shared by the single channel capture/compare timer modules.
// Assumes scct_map.svh is on the include path.
`include "scct_map.svh"

package scct_pkg;

  typedef enum logic [1:0] {
    SCCT_DIR_OUTPUT = 2'b00,
    SCCT_DIR_IN_SELF = 2'b01,
    SCCT_DIR_IN_NEIGHBOUR = 2'b10,
    SCCT_DIR_IN_TRIGGER = 2'b11
  } scct_dir_type;

  typedef enum logic [2:0] {
    SCCT_OC_TIMING = 3'b000,
    SCCT_OC_SET = 3'b001,
    SCCT_OC_CLEAR = 3'b010,
    SCCT_OC_TOGGLE = 3'b011,
    SCCT_OC_FORCE_LOW = 3'b100,
    SCCT_OC_FORCE_HIGH = 3'b101,
    SCCT_OC_PWM_A = 3'b110,
    SCCT_OC_PWM_B = 3'b111
  } scct_ocmode_type;

  typedef enum logic [1:0] {
    SCCT_EDGE_RISING = 2'b00,
    SCCT_EDGE_FALLING = 2'b01,
    SCCT_EDGE_RESERVED = 2'b10,
    SCCT_EDGE_BOTH = 2'b11
  } scct_edge_type;

endpackage : scct_pkg

// ---- scct_src.sv ----
// Signal source on the channel pins and the break pin.
// Assumes the bench starts the pulse train and sets the break level.
`timescale 1ns/1ns
module scct_src (
  input wire logic i_clock,
  input wire logic i_run,
  input wire logic i_brk,
  output logic o_pin,
  output logic o_brk_pin
);
  logic [2:0] cnt_r = 3'h0;
  initial o_pin = 1'b0;
  // A slow square wave keeps every edge well clear of the filter.
  always @(posedge i_clock) begin
    cnt_r <= cnt_r + 3'h1;
    if (i_run && cnt_r == 3'h7) o_pin <= ~o_pin;
  end
  assign o_brk_pin = i_brk;
endmodule : scct_src

// ---- scct_timer.sv ----
// Single channel capture/compare timer: 16-bit up counter with divider,
// reload, repetition, one channel for compare/PWM or capture, and a
// complementary output gated by a primary enable with break.
// Assumes a one-cycle strobe register port and asynchronous pins.
//
// Behaviour
// RULE_01: Shadowed compare value moves on update events.
// RULE_02: Software enables shadow for PWM unless one-shot.
// RULE_03: Shadow enable locked at level 11, output.
// RULE_04: Fast mode: trigger edge acts as match.
// RULE_05: Trigger to output: 5 cycles, 3 fast.
// RULE_06: Direction field writable only while channel disabled.
// RULE_07: Direction selects output or one input source.
// RULE_08: Input filter needs N agreeing divided samples.
// RULE_09: Capture every 1/2/4/8 edges; reset when disabled.
// RULE_10: Input polarity pair selects active edge.
// RULE_11: Output polarity bits invert main and comp.
// RULE_12: comp_out_en enables complementary output.
// RULE_13: chan_en enables output or capture events.
// RULE_14: Counter readable; writes replace count immediately.
// RULE_15: Divider is value plus one, loaded on update.
// RULE_16: Reload value sets counter wrap limit.
// RULE_17: Repetition counter down-counts overflows to updates.
// RULE_18: cc_value: capture read-only, or compare value.
// RULE_19: primary_out_en gates outputs; break clears asynchronously.
// RULE_20: auto_out_en sets primary enable on update.
// RULE_21: auto_out_en writable only at lock level 00.
// RULE_22: break_polarity selects break input active level.
// RULE_23: PWM A active below compare; B inverse.
// RULE_24: All registers and shadows reset to zero.
`timescale 1ns/1ns
`include "scct_map.svh"

module scct_timer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_chan_input,
  input wire logic i_neighbour_input,
  input wire logic i_break_input,
  input wire logic i_internal_trigger_in,
  output logic o_main_out,
  output logic o_main_oe,
  output logic o_comp_out,
  output logic o_comp_oe,
  output logic o_update_event
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic cnt_en_r;
  logic one_shot_mode_r;
  logic [1:0] trigger_source_field_r;
  logic [7:0] mode_r;
  logic chan_en_r;
  logic main_polarity_r;
  logic comp_out_en_r;
  logic comp_polarity_r;
  logic [15:0] count_value_r;
  logic [15:0] count_value_nxt;
  logic [15:0] clock_divider_value_r;
  logic [15:0] div_shadow_r;
  logic [15:0] div_cnt_r;
  logic [15:0] reload_value_r;
  logic [7:0] repeat_value_r;
  logic [7:0] rep_cnt_r;
  logic [15:0] cc_buf_r;
  logic [15:0] cc_value_r;
  logic primary_out_en_r;
  logic auto_out_en_r;
  logic break_polarity_r;
  logic [1:0] write_lock_level_r;
  logic lock_written_r;
  logic [15:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire wr_ctrl = i_wr && (i_addr == `SCCT_OFF_CTRL);
  wire wr_mode = i_wr && (i_addr == `SCCT_OFF_MODE);
  wire wr_outen = i_wr && (i_addr == `SCCT_OFF_OUTEN);
  wire wr_count = i_wr && (i_addr == `SCCT_OFF_COUNT);
  wire wr_div = i_wr && (i_addr == `SCCT_OFF_DIV);
  wire wr_reload = i_wr && (i_addr == `SCCT_OFF_RELOAD);
  wire wr_repeat = i_wr && (i_addr == `SCCT_OFF_REPEAT);
  wire wr_cc = i_wr && (i_addr == `SCCT_OFF_CCVAL);
  wire wr_write_lock_level = i_wr && (i_addr == `SCCT_OFF_WRITE_LOCK_LEVEL);

  wire [1:0] chan_direction_sel = mode_r[`SCCT_MODE_DIR_HI:`SCCT_MODE_DIR_LO];
  wire out_mode = chan_direction_sel == scct_pkg::SCCT_DIR_OUTPUT;
  wire compare_fast_en = mode_r[`SCCT_MODE_FAST];
  wire compare_shadow_en = mode_r[`SCCT_MODE_SHADOW];
  wire [2:0] oc_mode = mode_r[`SCCT_MODE_OCTL_HI:`SCCT_MODE_OCTL_LO];
  wire [1:0] capture_divider = mode_r[`SCCT_MODE_CDIV_HI:`SCCT_MODE_CDIV_LO];
  wire [3:0] input_filter_cfg = mode_r[`SCCT_MODE_FILT_HI:`SCCT_MODE_FILT_LO];

  // Lock levels: compare control locked at full lock in output mode,
  // polarity bits from level 10 upward in output mode, auto enable and break polarity
  // unless unlocked.
  wire lock_full_out = (write_lock_level_r == `SCCT_LOCK_FULL) && out_mode;
  wire lock_pol = write_lock_level_r[1] && out_mode;
  wire lock_any = write_lock_level_r != `SCCT_LOCK_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.

  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {i_break_input, i_neighbour_input, i_chan_input};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire break_sync_active = pin_sync_r[2] == break_polarity_r; // RULE_22
  // The raw pin clears the primary enable without waiting for a clock edge,
  // so outputs shut off even if the clock has stopped.
  wire break_async_active = i_break_input == break_polarity_r; // RULE_22

  ////////////////////////////////////////////////////////////////////////////
  // Input filters, source selection and edge detection.

  logic filtered_in_self;
  logic filtered_in_neighbour;

  scct_filter u_filter_self (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_level(pin_sync_r[0]),
    .i_cfg(input_filter_cfg),
    .o_filtered(filtered_in_self)
  ); // RULE_08

  scct_filter u_filter_neighbour (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_level(pin_sync_r[1]),
    .i_cfg(input_filter_cfg),
    .o_filtered(filtered_in_neighbour)
  ); // RULE_08

  wire internal_trig_sel = trigger_source_field_r == `SCCT_TRIG_INTERNAL;
  wire capture_input_sel =
    (chan_direction_sel == scct_pkg::SCCT_DIR_IN_SELF) ? filtered_in_self :
    (chan_direction_sel == scct_pkg::SCCT_DIR_IN_NEIGHBOUR) ? filtered_in_neighbour :
    (chan_direction_sel == scct_pkg::SCCT_DIR_IN_TRIGGER) ?
      (internal_trig_sel && i_internal_trigger_in) : 1'b0; // RULE_07

  logic cap_prev_r;
  wire cap_rise = capture_input_sel && !cap_prev_r;
  wire cap_fall = !capture_input_sel && cap_prev_r;
  wire [1:0] edge_sel = {comp_polarity_r, main_polarity_r};
  wire cap_edge = (edge_sel == scct_pkg::SCCT_EDGE_RISING) ? cap_rise :
                  (edge_sel == scct_pkg::SCCT_EDGE_FALLING) ? cap_fall :
                  (edge_sel == scct_pkg::SCCT_EDGE_BOTH) ? (cap_rise || cap_fall) :
                  1'b0; // RULE_10

  logic capture_hit;

  scct_edge_div u_edge_div (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(chan_en_r && !out_mode),
    .i_edge(cap_edge),
    .i_div(capture_divider),
    .o_capture(capture_hit)
  ); // RULE_09 RULE_13

  wire trig_level =
    (trigger_source_field_r == `SCCT_TRIG_INTERNAL) ? i_internal_trigger_in :
    (trigger_source_field_r == `SCCT_TRIG_SELF) ? filtered_in_self :
    (trigger_source_field_r == `SCCT_TRIG_NEIGHBOUR) ? filtered_in_neighbour : 1'b0;

  logic trig_prev_r;
  logic [`SCCT_TRIG_PIPE_W-1:0] trig_pipe_r;
  wire trig_edge = trig_level && !trig_prev_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cap_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
      trig_pipe_r <= '0;
    end else begin
      cap_prev_r <= capture_input_sel;
      trig_prev_r <= trig_level;
      trig_pipe_r <= {trig_pipe_r[`SCCT_TRIG_PIPE_W-2:0], trig_edge};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, divider and repetition.

  wire div_tick = div_cnt_r == div_shadow_r; // RULE_15
  wire count_step = cnt_en_r && div_tick;
  wire overflow = count_step && (count_value_r == reload_value_r); // RULE_16
  wire upd_gen = wr_ctrl && i_wdata[`SCCT_CTRL_UPD_GEN];
  wire update_event = upd_gen || (overflow && (rep_cnt_r == 8'h00)); // RULE_17

  assign count_value_nxt = wr_count ? i_wdata :
                           upd_gen ? 16'h0000 :
                           overflow ? 16'h0000 :
                           count_step ? count_value_r + 16'h0001 :
                           count_value_r; // RULE_14

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      count_value_r <= `SCCT_RST16;
      div_cnt_r <= `SCCT_RST16;
      div_shadow_r <= `SCCT_RST16;
      rep_cnt_r <= `SCCT_RST8;
    end else begin
      count_value_r <= count_value_nxt; // RULE_14
      div_cnt_r <= (upd_gen || div_tick || !cnt_en_r) ? 16'h0000 : div_cnt_r + 16'h0001;
      if (update_event) begin
        div_shadow_r <= clock_divider_value_r; // RULE_15
        rep_cnt_r <= repeat_value_r; // RULE_17
      end else if (overflow) begin
        rep_cnt_r <= rep_cnt_r - 8'h01; // RULE_17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare logic and output reference.

  logic out_ref_r;
  logic out_ref_nxt;
  logic pwm_lvl_prev_r;
  logic was_pwm_r;

  // A match counts only when the counter has just stepped onto the value,
  // so toggle mode does not toggle every cycle of a slow divider.
  wire match_evt = cnt_en_r && (div_cnt_r == 16'h0000) && (count_value_r == cc_value_r);
  wire is_pwm = (oc_mode == scct_pkg::SCCT_OC_PWM_A) || (oc_mode == scct_pkg::SCCT_OC_PWM_B);
  wire below = count_value_r < cc_value_r;
  wire pwm_lvl = (oc_mode == scct_pkg::SCCT_OC_PWM_A) ? below : !below; // RULE_23
  wire trig_hit = is_pwm && (compare_fast_en ? trig_pipe_r[`SCCT_FAST_LATENCY-3] :
                             trig_pipe_r[`SCCT_SLOW_LATENCY-3]); // RULE_04 RULE_05

  always_comb begin
    out_ref_nxt = out_ref_r;
    if (trig_hit) begin
      out_ref_nxt = 1'b1; // RULE_04
    end else begin
      unique case (oc_mode)
        scct_pkg::SCCT_OC_TIMING: out_ref_nxt = out_ref_r;
        scct_pkg::SCCT_OC_SET: out_ref_nxt = match_evt ? 1'b1 : out_ref_r;
        scct_pkg::SCCT_OC_CLEAR: out_ref_nxt = match_evt ? 1'b0 : out_ref_r;
        scct_pkg::SCCT_OC_TOGGLE: out_ref_nxt = match_evt ? !out_ref_r : out_ref_r;
        scct_pkg::SCCT_OC_FORCE_LOW: out_ref_nxt = 1'b0;
        scct_pkg::SCCT_OC_FORCE_HIGH: out_ref_nxt = 1'b1;
        scct_pkg::SCCT_OC_PWM_A, scct_pkg::SCCT_OC_PWM_B: begin
          if (!was_pwm_r || (pwm_lvl != pwm_lvl_prev_r)) begin
            out_ref_nxt = pwm_lvl; // RULE_23
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      out_ref_r <= 1'b0;
      pwm_lvl_prev_r <= 1'b0;
      was_pwm_r <= 1'b0;
    end else begin
      out_ref_r <= out_mode ? out_ref_nxt : 1'b0;
      pwm_lvl_prev_r <= pwm_lvl;
      was_pwm_r <= out_mode && is_pwm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_en_r <= 1'b0; // RULE_24
      one_shot_mode_r <= 1'b0;
      trigger_source_field_r <= `SCCT_TRIG_NONE;
      mode_r <= `SCCT_RST8;
      chan_en_r <= 1'b0;
      main_polarity_r <= 1'b0;
      comp_out_en_r <= 1'b0;
      comp_polarity_r <= 1'b0;
      clock_divider_value_r <= `SCCT_RST16;
      reload_value_r <= `SCCT_RST16;
      repeat_value_r <= `SCCT_RST8;
      cc_buf_r <= `SCCT_RST16;
      cc_value_r <= `SCCT_RST16;
      auto_out_en_r <= 1'b0;
      break_polarity_r <= 1'b0;
      write_lock_level_r <= `SCCT_LOCK_NONE;
      lock_written_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cnt_en_r <= i_wdata[`SCCT_CTRL_CNT_EN];
        one_shot_mode_r <= i_wdata[`SCCT_CTRL_ONE_SHOT];
        trigger_source_field_r <= i_wdata[`SCCT_CTRL_TRIG_HI:`SCCT_CTRL_TRIG_LO];
      end else if (update_event && one_shot_mode_r) begin
        cnt_en_r <= 1'b0;
      end
      if (wr_mode) begin
        if (!chan_en_r) begin
          mode_r[1:0] <= i_wdata[1:0]; // RULE_06
        end
        mode_r[`SCCT_MODE_FAST] <= i_wdata[`SCCT_MODE_FAST];
        if (!lock_full_out) begin
          mode_r[`SCCT_MODE_SHADOW] <= i_wdata[`SCCT_MODE_SHADOW]; // RULE_03
          mode_r[`SCCT_MODE_OCTL_HI:`SCCT_MODE_OCTL_LO] <=
            i_wdata[`SCCT_MODE_OCTL_HI:`SCCT_MODE_OCTL_LO];
        end
        mode_r[`SCCT_MODE_FILT_HI] <= i_wdata[`SCCT_MODE_FILT_HI];
      end
      if (wr_outen) begin
        chan_en_r <= i_wdata[`SCCT_OUTEN_CHAN_EN]; // RULE_13
        comp_out_en_r <= i_wdata[`SCCT_OUTEN_COMP_EN]; // RULE_12
        if (!lock_pol) begin
          main_polarity_r <= i_wdata[`SCCT_OUTEN_MAIN_POL]; // RULE_11
          comp_polarity_r <= i_wdata[`SCCT_OUTEN_COMP_POL];
        end
      end
      if (wr_div) begin
        clock_divider_value_r <= i_wdata;
      end
      if (wr_reload) begin
        reload_value_r <= i_wdata; // RULE_16
      end
      if (wr_repeat) begin
        repeat_value_r <= i_wdata[7:0];
      end
      // Captured values are read-only; compare writes bypass the buffer
      // when the shadow is off.
      if (!out_mode) begin
        if (capture_hit) begin
          cc_value_r <= count_value_r; // RULE_18
        end
      end else if (update_event && compare_shadow_en) begin
        cc_value_r <= cc_buf_r; // RULE_01
      end else if (wr_cc && !compare_shadow_en) begin
        cc_value_r <= i_wdata; // RULE_18
      end
      if (wr_cc && out_mode) begin
        cc_buf_r <= i_wdata; // RULE_01
      end
      if (wr_write_lock_level) begin
        if (!lock_any) begin
          auto_out_en_r <= i_wdata[`SCCT_WRITE_LOCK_LEVEL_AUTO_EN]; // RULE_21
          break_polarity_r <= i_wdata[`SCCT_WRITE_LOCK_LEVEL_BRK_POL];
        end
        if (!lock_written_r) begin
          write_lock_level_r <= i_wdata[`SCCT_WRITE_LOCK_LEVEL_LEVEL_HI:`SCCT_WRITE_LOCK_LEVEL_LEVEL_LO];
          lock_written_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary enable and pin drivers; an active break clears the primary enable and both output enables at once.

  wire main_on = out_mode && chan_en_r && primary_out_en_r; // RULE_13 RULE_19
  wire comp_on = out_mode && comp_out_en_r && primary_out_en_r; // RULE_12 RULE_19

  always_ff @(posedge i_clock or posedge break_async_active) begin
    if (break_async_active) begin
      primary_out_en_r <= 1'b0; // RULE_19
      o_main_oe <= 1'b0;
      o_comp_oe <= 1'b0;
    end else if (!i_rst_n) begin
      primary_out_en_r <= 1'b0;
      o_main_oe <= 1'b0;
      o_comp_oe <= 1'b0;
    end else begin
      if (wr_write_lock_level) begin
        primary_out_en_r <= i_wdata[`SCCT_WRITE_LOCK_LEVEL_PRIM_EN];
      end else if (update_event && auto_out_en_r && !break_sync_active) begin
        primary_out_en_r <= 1'b1; // RULE_20
      end
      o_main_oe <= main_on;
      o_comp_oe <= comp_on;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_main_out <= 1'b0;
      o_comp_out <= 1'b0;
      o_update_event <= 1'b0;
    end else begin
      o_main_out <= main_on ? (out_ref_r ^ main_polarity_r) : main_polarity_r; // RULE_11
      o_comp_out <= comp_on ? (!out_ref_r ^ comp_polarity_r) : comp_polarity_r; // RULE_11
      o_update_event <= update_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand for the single cycle after the strobe.

  wire [15:0] rd_mux =
    (i_addr == `SCCT_OFF_CTRL) ? {10'h000, trigger_source_field_r, one_shot_mode_r,
                                  2'b00, cnt_en_r} :
    (i_addr == `SCCT_OFF_MODE) ? {8'h00, mode_r} :
    (i_addr == `SCCT_OFF_OUTEN) ? {12'h000, comp_polarity_r, comp_out_en_r,
                                   main_polarity_r, chan_en_r} :
    (i_addr == `SCCT_OFF_COUNT) ? count_value_r :
    (i_addr == `SCCT_OFF_DIV) ? clock_divider_value_r :
    (i_addr == `SCCT_OFF_RELOAD) ? reload_value_r :
    (i_addr == `SCCT_OFF_REPEAT) ? {8'h00, repeat_value_r} :
    (i_addr == `SCCT_OFF_CCVAL) ? cc_value_r :
    (i_addr == `SCCT_OFF_WRITE_LOCK_LEVEL) ? {primary_out_en_r, auto_out_en_r, break_polarity_r,
                                  3'b000, write_lock_level_r, 8'h00} :
    16'h0000;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_r <= `SCCT_RST16;
    end else begin
      rdata_r <= i_rd ? rd_mux : 16'h0000;
    end
  end

  assign o_rdata = rdata_r;

endmodule : scct_timer

// ---- scct_timer_props.sv ----
// Register port checker for the capture/compare timer.
// Assumes readback pairs are issued while the counter is stopped.
`timescale 1ns/1ns
module scct_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_update_event
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire mapped = i_addr inside {8'h00, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h44};
  ////////////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  unmapped_zero_a: assert property (i_rd && !mapped |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  upd_bit_a: assert property (i_rd && i_addr == 8'h00 |=> !o_rdata[1])
    else $error("update bit stored");
  sw_update_a: assert property (i_wr && i_addr == 8'h00 && i_wdata[1]
    |-> ##[1:2] o_update_event) else $error("no update event");
  div_back_a: assert property (i_wr && i_addr == 8'h28 ##1 i_rd && i_addr == 8'h28
    |=> o_rdata == $past(i_wdata, 2)) else $error("divider readback");
  reload_back_a: assert property (i_wr && i_addr == 8'h2c ##1 i_rd && i_addr == 8'h2c
    |=> o_rdata == $past(i_wdata, 2)) else $error("reload readback");
  count_back_a: assert property (i_wr && i_addr == 8'h24 ##1 i_rd && i_addr == 8'h24
    |=> o_rdata == $past(i_wdata, 2)) else $error("count readback");
  rep_back_a: assert property (i_wr && i_addr == 8'h30 ##1 i_rd && i_addr == 8'h30
    |=> o_rdata == ($past(i_wdata, 2) & 16'h00ff)) else $error("repeat readback");
endmodule : scct_props
bind scct_timer scct_props props_u (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_update_event);

// ---- tb.sv ----
// Self-checking bench of the timer: registers, PWM, shadow, break, capture.
// Assumes scct_src drives the pins and scct_props is bound to the design.
`timescale 1ns/1ns
module tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic run = 1'b0;
  logic brk = 1'b0;
  logic pin, brk_pin, o_main_out, o_main_oe, o_comp_out, o_comp_oe;
  logic [15:0] o_rdata, v, n;
  logic [31:0] seed = 32'h0000_561a;
  logic [7:0] map [10] = '{8'h00, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h44, 8'h48};
  logic [7:0] ra [4] = '{8'h28, 8'h2c, 8'h30, 8'h24};
  logic [15:0] rm [4] = '{16'hffff, 16'hffff, 16'h00ff, 16'hffff};
  int n_errors = 0;
  int check_count = 0;
  int hi, lo;
  initial forever #10 i_clock = ~i_clock;
  scct_src src_u (.i_clock(i_clock), .i_run(run), .i_brk(brk), .o_pin(pin),
    .o_brk_pin(brk_pin));
  scct_timer dut_u (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_chan_input(pin), .i_neighbour_input(~pin), .i_break_input(brk_pin),
    .i_internal_trigger_in(run), .o_main_out, .o_main_oe, .o_comp_out, .o_comp_oe,
    .o_update_event());
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // The write strobe is left up so back-to-back transfers need no gap.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e, what);
    @(posedge i_clock);
  endtask : rd
  task automatic nop(input int c);
    i_wr <= 1'b0;
    repeat (c) @(posedge i_clock);
  endtask : nop
  task automatic rst();
    i_rst_n <= 1'b0;
    nop(4);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
  endtask : rst
  task automatic count();
    hi = 0;
    lo = 0;
    repeat (40) begin
      @(posedge i_clock);
      #1 hi += o_main_out;
      lo += o_comp_out;
    end
  endtask : count
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000 n_errors++;
    print_verdict();
  end
  initial begin
    rst();
    foreach (map[i]) rd(map[i], 16'h0000, "reset");
    foreach (ra[i]) begin
      v = rnd();
      wr(ra[i], v);
      rd(ra[i], v & rm[i], "readback");
      wr(ra[i], 16'h0000);
    end
    $display("Test registers done");
    v = rnd() % 16'h0012 + 16'h0001;
    wr(8'h44, 16'h6000);
    wr(8'h20, 16'h0005);
    wr(8'h34, v);
    wr(8'h2c, 16'h0013);
    wr(8'h00, 16'h0003);
    for (int m = 6; m < 8; m++) begin
      wr(8'h18, 16'(m << 4));
      nop(4);
      count();
      n = (m == 6) ? v << 1 : 16'h0028 - (v << 1);
      chk(16'(hi), n, "main highs");
      chk(16'(lo), 16'h0028 - n, "comp highs");
      chk(16'({o_main_oe, o_comp_oe}), 16'h0003, "oe on");
    end
    wr(8'h18, 16'h0068);
    n = rnd() % 16'h0012 + 16'h0001;
    wr(8'h34, n);
    rd(8'h34, v, "cc active");
    nop(25);
    rd(8'h34, n, "cc updated");
    brk <= 1'b1;
    nop(2);
    chk(16'({o_main_oe, o_comp_oe}), 16'h0000, "oe break");
    rd(8'h44, 16'h6000, "break primary_out_en");
    $display("Test output done");
    brk <= 1'b0;
    rst();
    wr(8'h44, 16'h0300);
    wr(8'h44, 16'h6300);
    rd(8'h44, 16'h0300, "lock");
    wr(8'h18, 16'h0008);
    rd(8'h18, 16'h0000, "shadow lock");
    wr(8'h20, 16'h0001);
    wr(8'h18, 16'h0001);
    rd(8'h18, 16'h0000, "dir lock");
    wr(8'h20, 16'h0000);
    wr(8'h18, 16'h0001);
    rd(8'h18, 16'h0001, "dir");
    v = rnd();
    wr(8'h20, 16'h0001);
    wr(8'h24, v);
    run <= 1'b1;
    nop(60);
    rd(8'h34, v, "capture");
    $display("Test capture done");
    print_verdict();
  end
endmodule : tb
